/* File: src/vme_slave_address_decoder.sv */
// VME slave address decoder with base, slot and shared addressing
`timescale 1ns/100ps
module vme_slave_address_decoder (
    // Clock and reset
    input wire logic SYS_CLK,
    input wire logic RESET_N,
    // Bus request, strobe held for the whole cycle
    input wire logic STROBE,
    input wire vme_dec_pkg::vme_req_t REQ,
    // Backplane straps
    input wire logic [4:0] SLOT_NUMBER_LINES,
    input wire logic AUX_CONNECTOR_PRESENT,
    input wire logic [15:0] ROTARY_BASE,
    // Daisy chain token in and out
    input wire logic TOKEN_IN,
    output logic TOKEN_OUT,
    // Answers
    output logic ACK,
    output logic [15:0] RDATA,
    output logic BUF_READ,
    output logic FRAME_TAG_VALID,
    output logic [31:0] FRAME_TAG,
    output vme_dec_pkg::acc_kind_t ACC_KIND
);
    // ==========================================================
    // State
    logic [15:0] mode_r;
    logic [7:0] base_hi_r;
    logic [7:0] base_lo_r;
    logic [7:0] mcast_r;
    logic [1:0] chain_r;
    logic [4:0] slot_r;
    logic slot_cap_r;
    logic strobe_d_r;
    logic done_r;
    logic holder_r;
    logic ack_r;
    logic [15:0] rdata_r;
    logic buf_rd_r;
    logic tag_v_r;
    vme_dec_pkg::acc_kind_t kind_r;

    // ==========================================================
    // Modifier classes
    wire [5:0] am = REQ.am;
    wire is_a24 = (am == vme_dec_pkg::AM_A24_SUP_BLT) ||
        (am == vme_dec_pkg::AM_A24_SUP_DATA) ||
        (am == vme_dec_pkg::AM_A24_SUP_MBLT) ||
        (am == vme_dec_pkg::AM_A24_USR_BLT) ||
        (am == vme_dec_pkg::AM_A24_USR_DATA) ||
        (am == vme_dec_pkg::AM_A24_USR_MBLT);
    wire is_a32_blt = (am == vme_dec_pkg::AM_A32_SUP_BLT) ||
        (am == vme_dec_pkg::AM_A32_USR_BLT) ||
        (am == vme_dec_pkg::AM_A32_SUP_MBLT) ||
        (am == vme_dec_pkg::AM_A32_USR_MBLT);
    wire is_a32_data = (am == vme_dec_pkg::AM_A32_SUP_DATA) ||
        (am == vme_dec_pkg::AM_A32_USR_DATA);
    wire is_a32 = is_a32_blt || is_a32_data;
    wire is_csr = (am == vme_dec_pkg::AM_CSR);

    // ==========================================================
    // Address compare
    wire [15:0] base_sel = mode_r[vme_dec_pkg::BIT_SEL_REGS] ?
        {base_hi_r, base_lo_r} : ROTARY_BASE;
    wire [15:0] ofs = REQ.addr[15:0];
    // Named slices so the checks can look one edge back
    wire [7:0] top_byte = REQ.addr[31:24];
    wire [7:0] mid_byte = REQ.addr[23:16];
    wire req_wr = REQ.write;
    wire is_buf = (ofs <= vme_dec_pkg::OFS_BUF_LAST);
    // Only the upper bytes take part in base hits; slot and shared hits also test the offset
    wire hit_a24 = is_a24 && (REQ.addr[23:16] == base_sel[7:0]);
    wire hit_a32 = is_a32 && (REQ.addr[31:16] == base_sel);
    wire geo_ok = is_csr && AUX_CONNECTOR_PRESENT &&
        (REQ.addr[23:19] == slot_r) &&
        (REQ.addr[18:16] == 3'h0);
    wire hit_geo = geo_ok && !is_buf;
    wire shr_addr = (REQ.addr[31:24] == mcast_r) &&
        (REQ.addr[23:16] == 8'h00);
    wire role_on = (chain_r != vme_dec_pkg::ROLE_INACTIVE);
    // Chain read: block code, read, buffer only; multicast: data, write
    wire shr_cblt = is_a32_blt && !REQ.write && is_buf;
    wire shr_multicast_write = is_a32_data && REQ.write && !is_buf;
    wire hit_shr = shr_addr && role_on && (shr_cblt || shr_multicast_write);
    // A first board holds the token at once; others wait for it
    wire first = chain_r[vme_dec_pkg::BIT_CHAIN_FIRST];
    wire last = chain_r[vme_dec_pkg::BIT_CHAIN_LAST];
    wire token_have = first && !last || TOKEN_IN;
    wire hit_any = hit_a24 || hit_a32 || hit_geo || hit_shr;
    wire start = STROBE && !strobe_d_r && !done_r;
    // Shared access outranks a base hit on the same address
    wire take_base = start && (hit_a24 || hit_a32) && !hit_shr;
    wire take_geo = start && hit_geo && !take_base;
    wire take_shr = STROBE && !done_r && hit_shr && token_have &&
        !take_base && !take_geo;
    wire take = take_base || take_geo || take_shr;
    wire do_wr = take && REQ.write;

    // ==========================================================
    // Write decode, shared write lands like any other write
    wire wr_mode = do_wr && (ofs == vme_dec_pkg::OFS_BIT_SET);
    wire wr_clr = do_wr && (ofs == vme_dec_pkg::OFS_BIT_CLR);
    wire wr_hi = do_wr && (ofs == vme_dec_pkg::OFS_BASE_HI);
    wire wr_lo = do_wr && (ofs == vme_dec_pkg::OFS_BASE_LO);
    wire wr_mc = do_wr && (ofs == vme_dec_pkg::OFS_MCAST_ADDR);
    wire wr_ch = do_wr && (ofs == vme_dec_pkg::OFS_CHAIN_CTL);
    // Writable slot only without connector; the strap would fight it
    wire wr_slot = do_wr && !AUX_CONNECTOR_PRESENT &&
        (ofs == vme_dec_pkg::OFS_SLOT_ID);
    wire [15:0] mode_nxt = wr_mode ? (mode_r | REQ.wdata) :
        wr_clr ? (mode_r & ~REQ.wdata) : mode_r;
    logic [15:0] rd_mux;
    always_comb begin
        case (ofs)
            vme_dec_pkg::OFS_SLOT_ID: rd_mux = {11'h0, slot_r};
            vme_dec_pkg::OFS_MCAST_ADDR: rd_mux = {8'h00, mcast_r};
            vme_dec_pkg::OFS_BIT_SET: rd_mux = mode_r;
            vme_dec_pkg::OFS_BIT_CLR: rd_mux = mode_r;
            vme_dec_pkg::OFS_BASE_HI: rd_mux = {8'h00, base_hi_r};
            vme_dec_pkg::OFS_BASE_LO: rd_mux = {8'h00, base_lo_r};
            vme_dec_pkg::OFS_CHAIN_CTL: rd_mux = {14'h0, chain_r};
            default: rd_mux = 16'h0000;
        endcase
    end
    // Access kind shows for the answer cycle only
    vme_dec_pkg::acc_kind_t kind_nxt;
    assign kind_nxt = take_base ? vme_dec_pkg::ACC_BASE :
        take_geo ? vme_dec_pkg::ACC_GEO :
        take_shr ? vme_dec_pkg::ACC_SHARED : vme_dec_pkg::ACC_NONE;

    // ==========================================================
    // Slot capture one edge after reset release
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            slot_cap_r <= 1'b1;
            slot_r <= vme_dec_pkg::RST_SLOT;
        end else begin
            slot_cap_r <= 1'b0;
            if (slot_cap_r && AUX_CONNECTOR_PRESENT) begin
                slot_r <= SLOT_NUMBER_LINES;
            end else if (wr_slot) begin
                slot_r <= REQ.wdata[4:0];
            end
        end
    end

    // Control registers
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            mode_r <= vme_dec_pkg::RST_MODE;
            base_hi_r <= vme_dec_pkg::RST_BASE;
            base_lo_r <= vme_dec_pkg::RST_BASE;
            mcast_r <= vme_dec_pkg::RST_MCAST_ADDR;
            chain_r <= vme_dec_pkg::RST_CHAIN;
        end else begin
            mode_r <= mode_nxt;
            if (wr_hi) base_hi_r <= REQ.wdata[7:0];
            if (wr_lo) base_lo_r <= REQ.wdata[7:0];
            if (wr_mc) mcast_r <= REQ.wdata[7:0];
            if (wr_ch) chain_r <= REQ.wdata[1:0];
        end
    end

    // Cycle tracking: one answer per strobe
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            strobe_d_r <= 1'b0;
            done_r <= 1'b0;
            holder_r <= 1'b0;
        end else begin
            strobe_d_r <= STROBE;
            done_r <= STROBE && (done_r || take);
            // Token leaves once this board ends its share of a shared access, chain read or multicast write
            holder_r <= STROBE && (holder_r || take_shr);
        end
    end

    // Answer registers
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            ack_r <= 1'b0;
            rdata_r <= 16'h0000;
            buf_rd_r <= 1'b0;
            tag_v_r <= 1'b0;
            kind_r <= vme_dec_pkg::ACC_NONE;
        end else begin
            ack_r <= take;
            rdata_r <= take ? rd_mux : rdata_r;
            buf_rd_r <= take && !REQ.write && is_buf;
            tag_v_r <= take_shr && !REQ.write;
            kind_r <= kind_nxt;
        end
    end

    // ==========================================================
    // Outputs
    assign ACK = ack_r;
    assign RDATA = rdata_r;
    assign BUF_READ = buf_rd_r;
    assign FRAME_TAG_VALID = tag_v_r;
    assign FRAME_TAG = {slot_r, 27'h0};
    assign ACC_KIND = kind_r;
    // Pass token on after own share, unless this board closes the chain
    assign TOKEN_OUT = holder_r && !STROBE ? 1'b0 :
        (done_r && kind_r == vme_dec_pkg::ACC_SHARED && !(last && !first));

    // ==========================================================
    // Checks
    // Answers are judged one edge after the take, from the registers,
    // so a broken take term cannot vouch for itself
    property p_no_ack_miss;
        @(posedge SYS_CLK) disable iff (!RESET_N)
        (STROBE && !hit_any) |=> !ack_r;
    endproperty
    a_no_ack_miss: assert property (p_no_ack_miss)
        else $error("ack on unmatched cycle");
    // A matched base cycle is answered on the next edge
    property p_base_ack;
        @(posedge SYS_CLK) disable iff (!RESET_N)
        (start && (hit_a24 || hit_a32) && !hit_shr) |=>
            ack_r && kind_r == vme_dec_pkg::ACC_BASE;
    endproperty
    a_base_ack: assert property (p_base_ack)
        else $error("matched base cycle not answered");
    // A matched slot cycle is answered on the next edge
    property p_geo_ack;
        @(posedge SYS_CLK) disable iff (!RESET_N)
        (start && geo_ok && !is_buf) |=>
            ack_r && kind_r == vme_dec_pkg::ACC_GEO;
    endproperty
    a_geo_ack: assert property (p_geo_ack)
        else $error("matched slot cycle not answered");
    property p_geo_csr;
        @(posedge SYS_CLK) disable iff (!RESET_N)
        (ack_r && kind_r == vme_dec_pkg::ACC_GEO) |->
            $past(is_csr) && !$past(is_buf);
    endproperty
    a_geo_csr: assert property (p_geo_csr)
        else $error("slot access with bad modifier or buffer");
    property p_geo_aux;
        @(posedge SYS_CLK) disable iff (!RESET_N)
        !AUX_CONNECTOR_PRESENT |->
            !(ack_r && kind_r == vme_dec_pkg::ACC_GEO);
    endproperty
    a_geo_aux: assert property (p_geo_aux)
        else $error("slot access without connector");
    property p_slot_cap;
        @(posedge SYS_CLK) disable iff (!RESET_N)
        (slot_cap_r && AUX_CONNECTOR_PRESENT) |=>
            slot_r == $past(SLOT_NUMBER_LINES);
    endproperty
    a_slot_cap: assert property (p_slot_cap)
        else $error("slot not latched after reset");
    // Slot register moves only at capture or a permitted write
    property p_slot_hold;
        @(posedge SYS_CLK) disable iff (!RESET_N)
        (!slot_cap_r && !wr_slot) |=> $stable(slot_r);
    endproperty
    a_slot_hold: assert property (p_slot_hold)
        else $error("slot register changed unprompted");
    // Shared answers, checked against the request one edge back
    property p_shr_match;
        @(posedge SYS_CLK) disable iff (!RESET_N)
        (ack_r && kind_r == vme_dec_pkg::ACC_SHARED) |->
            $past(top_byte) == $past(mcast_r) &&
            $past(mid_byte) == 8'h00 && $past(is_a32);
    endproperty
    a_shr_match: assert property (p_shr_match)
        else $error("shared access address mismatch");
    property p_shr_dir;
        @(posedge SYS_CLK) disable iff (!RESET_N)
        (ack_r && kind_r == vme_dec_pkg::ACC_SHARED) |->
            ($past(req_wr) && $past(is_a32_data) && !$past(is_buf)) ||
            (!$past(req_wr) && $past(is_a32_blt) && buf_rd_r);
    endproperty
    a_shr_dir: assert property (p_shr_dir)
        else $error("shared access wrong direction");
    property p_token;
        @(posedge SYS_CLK) disable iff (!RESET_N)
        (ack_r && kind_r == vme_dec_pkg::ACC_SHARED) |->
            $past(role_on) && ($past(TOKEN_IN) ||
            $past(chain_r) == vme_dec_pkg::ROLE_FIRST);
    endproperty
    a_token: assert property (p_token)
        else $error("shared access without token");
    // Frame tag only with an answered chain read of the buffer
    property p_tag_frame;
        @(posedge SYS_CLK) disable iff (!RESET_N)
        tag_v_r |->
            ack_r && buf_rd_r && kind_r == vme_dec_pkg::ACC_SHARED;
    endproperty
    a_tag_frame: assert property (p_tag_frame)
        else $error("frame tag outside chain read");
    // Last board keeps the token; others pass it only after a share
    property p_token_out;
        @(posedge SYS_CLK) disable iff (!RESET_N)
        TOKEN_OUT |-> ack_r && kind_r == vme_dec_pkg::ACC_SHARED &&
            chain_r != vme_dec_pkg::ROLE_LAST;
    endproperty
    a_token_out: assert property (p_token_out)
        else $error("token passed without own share");
    property p_base_sel;
        @(posedge SYS_CLK) disable iff (!RESET_N)
        (take_base && hit_a32 && mode_r[vme_dec_pkg::BIT_SEL_REGS]) |->
            REQ.addr[31:16] == {base_hi_r, base_lo_r};
    endproperty
    a_base_sel: assert property (p_base_sel)
        else $error("base compare used wrong source");
    property p_ack_pulse;
        @(posedge SYS_CLK) disable iff (!RESET_N)
        ack_r |=> !ack_r;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("ack longer than one cycle");
    c_base: cover property (@(posedge SYS_CLK) take_base);
    c_geo: cover property (@(posedge SYS_CLK) take_geo);
    c_multicast_write: cover property (@(posedge SYS_CLK) take_shr && REQ.write);
    c_cblt: cover property (@(posedge SYS_CLK) take_shr && !REQ.write);
    c_token: cover property (@(posedge SYS_CLK) TOKEN_OUT);
endmodule

/* File: include/vme_dec_pkg.sv */
// Package of constants and types for the VME slave address decoder
package vme_dec_pkg;
    // ==========================================================
    // Address modifier codes
    localparam logic [5:0] AM_A24_SUP_BLT = 6'h3f;
    localparam logic [5:0] AM_A24_SUP_DATA = 6'h3d;
    localparam logic [5:0] AM_A24_SUP_MBLT = 6'h3c;
    localparam logic [5:0] AM_A24_USR_BLT = 6'h3b;
    localparam logic [5:0] AM_A24_USR_DATA = 6'h39;
    localparam logic [5:0] AM_A24_USR_MBLT = 6'h38;
    localparam logic [5:0] AM_CSR = 6'h2f;
    localparam logic [5:0] AM_A32_SUP_BLT = 6'h0f;
    localparam logic [5:0] AM_A32_SUP_DATA = 6'h0d;
    localparam logic [5:0] AM_A32_SUP_MBLT = 6'h0c;
    localparam logic [5:0] AM_A32_USR_BLT = 6'h0b;
    localparam logic [5:0] AM_A32_USR_DATA = 6'h09;
    localparam logic [5:0] AM_A32_USR_MBLT = 6'h08;
    // ==========================================================
    // Register offsets (A[15:0])
    localparam logic [15:0] OFS_BUF_LAST = 16'h0ffc;
    localparam logic [15:0] OFS_SLOT_ID = 16'h1002;
    localparam logic [15:0] OFS_MCAST_ADDR = 16'h1004;
    localparam logic [15:0] OFS_BIT_SET = 16'h1006;
    localparam logic [15:0] OFS_BIT_CLR = 16'h1008;
    localparam logic [15:0] OFS_BASE_HI = 16'h1012;
    localparam logic [15:0] OFS_BASE_LO = 16'h1014;
    localparam logic [15:0] OFS_CHAIN_CTL = 16'h101a;
    // ==========================================================
    // Field positions and reset values
    localparam int BIT_SEL_REGS = 4;
    localparam int BIT_CHAIN_FIRST = 1;
    localparam int BIT_CHAIN_LAST = 0;
    localparam logic [7:0] RST_MCAST_ADDR = 8'haa;
    localparam logic [7:0] RST_BASE = 8'h00;
    localparam logic [15:0] RST_MODE = 16'h0000;
    localparam logic [1:0] RST_CHAIN = 2'h0;
    localparam logic [4:0] RST_SLOT = 5'h00;
    localparam int SLOT_MSB_POS = 27;
    // ==========================================================
    // Bus request carried as one struct
    typedef struct packed {
        logic [31:0] addr;
        logic [5:0] am;
        logic write;
        logic [15:0] wdata;
    } vme_req_t;
    // Chain role
    typedef enum logic [1:0] {
        ROLE_INACTIVE = 2'b00,
        ROLE_LAST = 2'b01,
        ROLE_FIRST = 2'b10,
        ROLE_MIDDLE = 2'b11
    } chain_role_t;
    // Access class
    typedef enum logic [1:0] {
        ACC_NONE = 2'b00,
        ACC_BASE = 2'b01,
        ACC_GEO = 2'b10,
        ACC_SHARED = 2'b11
    } acc_kind_t;
endpackage

/* File: dv/vme_master_model.sv */
// Bus master model that runs one decoder cycle at a time
`timescale 1ns/100ps
module vme_master_model (
    // Clock
    input wire logic SYS_CLK,
    // Request and upstream token
    output logic STROBE,
    output vme_dec_pkg::vme_req_t REQ,
    output logic TOKEN_IN,
    // Answers seen from the decoder
    input wire logic ACK,
    input wire logic [15:0] RDATA,
    input wire logic BUF_READ,
    input wire logic FRAME_TAG_VALID,
    input wire logic [31:0] FRAME_TAG,
    input wire vme_dec_pkg::acc_kind_t ACC_KIND,
    input wire logic TOKEN_OUT
);
    // ==========================================================
    // Snapshot taken in the single cycle that ACK stands
    logic ok = 1'b0;
    logic bufr, ftv, tok;
    logic [15:0] rd;
    logic [31:0] tag;
    vme_dec_pkg::acc_kind_t kind;
    initial begin
        STROBE = 1'b0;
        REQ = '0;
        TOKEN_IN = 1'b0;
    end
    // Predecessor board hands the token on
    task automatic set_token(input logic v);
        @(negedge SYS_CLK);
        TOKEN_IN <= v;
    endtask
    // Hold the request until ACK or four edges, then release
    task automatic xfer(input logic [31:0] a, input logic [5:0] m,
                        input logic w, input logic [15:0] d);
        @(negedge SYS_CLK);
        STROBE <= 1'b1;
        REQ <= {a, m, w, d};
        ok = 1'b0;
        for (int i = 0; i < 4 && !ok; i++) begin
            @(negedge SYS_CLK);
            if (ACK === 1'b1) begin
                ok = 1'b1;
                rd = RDATA;
                kind = ACC_KIND;
                bufr = BUF_READ;
                ftv = FRAME_TAG_VALID;
                tag = FRAME_TAG;
                tok = TOKEN_OUT;
            end
        end
        // Keep the request up across the edge that samples ACK high
        if (ok) begin
            @(negedge SYS_CLK);
        end
        // Released lines show the inverse, never a stale copy
        STROBE <= 1'b0;
        REQ <= ~REQ;
        @(negedge SYS_CLK);
    endtask
endmodule

/* File: dv/vme_slave_address_decoder_tb.sv */
// Self-checking bench for the VME slave address decoder
`timescale 1ns/100ps
module vme_slave_address_decoder_tb;
    // ==========================================================
    // Clock, straps and wiring
    logic SYS_CLK = 1'b0;
    logic RESET_N = 1'b0;
    logic AUX = 1'b1;
    logic [4:0] slot = 5'h05;
    logic STROBE, TOKEN_IN, TOKEN_OUT, ACK, BUF_READ, FTV;
    logic [15:0] RDATA;
    logic [31:0] FTAG;
    vme_dec_pkg::vme_req_t REQ;
    vme_dec_pkg::acc_kind_t KIND;
    logic [15:0] mc = vme_dec_pkg::OFS_MCAST_ADDR;
    logic [5:0] a32 = vme_dec_pkg::AM_A32_USR_DATA;
    int fails = 0;
    int total_checks = 0;
    always #25 SYS_CLK = ~SYS_CLK;
    // Switch base fixed: A32 0xcc11xxxx, A24 0x11xxxx
    vme_slave_address_decoder uut (
        .SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .STROBE(STROBE), .REQ(REQ),
        .SLOT_NUMBER_LINES(slot), .AUX_CONNECTOR_PRESENT(AUX),
        .ROTARY_BASE(16'hcc11), .TOKEN_IN(TOKEN_IN), .TOKEN_OUT(TOKEN_OUT),
        .ACK(ACK), .RDATA(RDATA), .BUF_READ(BUF_READ),
        .FRAME_TAG_VALID(FTV), .FRAME_TAG(FTAG), .ACC_KIND(KIND)
    );
    vme_master_model mst (
        .SYS_CLK(SYS_CLK), .STROBE(STROBE), .REQ(REQ), .TOKEN_IN(TOKEN_IN),
        .ACK(ACK), .RDATA(RDATA), .BUF_READ(BUF_READ),
        .FRAME_TAG_VALID(FTV), .FRAME_TAG(FTAG), .ACC_KIND(KIND),
        .TOKEN_OUT(TOKEN_OUT)
    );
    // ==========================================================
    // Shared helpers
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic go(input logic [31:0] a, input logic [5:0] m,
                      input logic w, input logic [15:0] d, input logic e);
        mst.xfer(a, m, w, d);
        chk(mst.ok, e);
    endtask
    task automatic rd_at(input logic [31:0] a, input logic [5:0] m,
                         input logic e);
        go(a, m, 1'b0, 16'h0000, e);
    endtask
    // Slot address with don't-care top byte set high on purpose
    function automatic logic [31:0] ga(input logic [15:0] o);
        return {8'hff, slot, 3'h0, o};
    endfunction
    task automatic geo_w(input logic [15:0] o, input logic [15:0] d);
        go(ga(o), vme_dec_pkg::AM_CSR, 1'b1, d, 1'b1);
    endtask
    task automatic geo_r(input logic [15:0] o, input logic [15:0] e);
        rd_at(ga(o), vme_dec_pkg::AM_CSR, 1'b1);
        chk(mst.rd, e);
    endtask
    task automatic sh_w(input logic [31:0] a, input logic e);
        go(a, vme_dec_pkg::AM_A32_SUP_DATA, 1'b1, 16'h0055, e);
    endtask
    task automatic do_reset(input logic [4:0] s, input logic x);
        @(negedge SYS_CLK);
        RESET_N = 1'b0;
        slot = s;
        AUX = x;
        repeat (4) @(negedge SYS_CLK);
        RESET_N = 1'b1;
        repeat (2) @(negedge SYS_CLK);
    endtask
    // ==========================================================
    // Scenarios
    task automatic t_reset_vals;
        geo_r(mc, 16'h00aa);
        chk(mst.kind, vme_dec_pkg::ACC_GEO);
        geo_r(vme_dec_pkg::OFS_CHAIN_CTL, 16'h0000);
        geo_r(vme_dec_pkg::OFS_BASE_HI, 16'h0000);
        geo_r(vme_dec_pkg::OFS_BIT_SET, 16'h0000);
    endtask
    task automatic t_geo_refuse;
        rd_at(ga(mc) ^ 32'h0008_0000, vme_dec_pkg::AM_CSR, 1'b0);
        rd_at(ga(mc) ^ 32'h0001_0000, vme_dec_pkg::AM_CSR, 1'b0);
        rd_at(ga(16'h0ffc), vme_dec_pkg::AM_CSR, 1'b0);
        rd_at(ga(mc), vme_dec_pkg::AM_A24_SUP_DATA, 1'b0);
        rd_at({16'h0011, mc}, 6'h3e, 1'b0);
    endtask
    task automatic t_base_codes;
        logic [5:0] c24 [6];
        logic [5:0] c32 [6];
        c24 = '{6'h3f, 6'h3d, 6'h3c, 6'h3b, 6'h39, 6'h38};
        c32 = '{6'h0f, 6'h0d, 6'h0c, 6'h0b, 6'h09, 6'h08};
        foreach (c24[i]) begin
            rd_at({16'h0011, mc}, c24[i], 1'b1);
            chk(mst.kind, vme_dec_pkg::ACC_BASE);
        end
        foreach (c32[i]) rd_at({16'hcc11, mc}, c32[i], 1'b1);
        chk(mst.rd, 16'h00aa);
        rd_at({16'hcc12, mc}, a32, 1'b0);
        rd_at({16'h0010, mc}, vme_dec_pkg::AM_A24_USR_DATA, 1'b0);
    endtask
    task automatic t_prog_base;
        geo_w(vme_dec_pkg::OFS_BASE_HI, 16'h0033);
        geo_w(vme_dec_pkg::OFS_BASE_LO, 16'h0044);
        rd_at({16'h3344, mc}, a32, 1'b0);
        geo_w(vme_dec_pkg::OFS_BIT_SET, 16'h0010);
        rd_at({16'h3344, mc}, a32, 1'b1);
        rd_at({16'h0044, mc}, vme_dec_pkg::AM_A24_USR_DATA, 1'b1);
        rd_at({16'hcc11, mc}, a32, 1'b0);
        geo_w(vme_dec_pkg::OFS_BIT_CLR, 16'h0010);
        rd_at({16'hcc11, mc}, a32, 1'b1);
    endtask
    // One board taken through first, middle and last chain roles; its shared byte is unique in the crate
    task automatic t_chain;
        sh_w({16'haa00, mc}, 1'b0);
        geo_w(vme_dec_pkg::OFS_CHAIN_CTL, 16'h0002);
        sh_w({16'haa00, mc}, 1'b1);
        chk(mst.kind, vme_dec_pkg::ACC_SHARED);
        chk(mst.tok, 1'b1);
        geo_r(mc, 16'h0055);
        rd_at(32'h5500_0000, vme_dec_pkg::AM_A32_SUP_BLT, 1'b1);
        chk({mst.bufr, mst.ftv}, 2'h3);
        chk(mst.tag, {slot, 27'h0});
        rd_at({16'h5500, mc}, vme_dec_pkg::AM_A32_USR_BLT, 1'b0);
        rd_at({16'h5500, mc}, a32, 1'b0);
        sh_w(32'h5500_0000, 1'b0);
        sh_w({16'h5501, mc}, 1'b0);
        geo_w(vme_dec_pkg::OFS_CHAIN_CTL, 16'h0003);
        sh_w({16'h5500, mc}, 1'b0);
        mst.set_token(1'b1);
        sh_w({16'h5500, mc}, 1'b1);
        chk(mst.tok, 1'b1);
        geo_w(vme_dec_pkg::OFS_CHAIN_CTL, 16'h0001);
        sh_w({16'h5500, mc}, 1'b1);
        chk(mst.tok, 1'b0);
        mst.set_token(1'b0);
    endtask
    // Mid-run resets re-latch the slot strap only with the connector present
    task automatic t_no_aux;
        do_reset(5'h07, 1'b0);
        rd_at(ga(mc), vme_dec_pkg::AM_CSR, 1'b0);
        go({16'hcc11, vme_dec_pkg::OFS_SLOT_ID}, a32, 1'b1, 16'h0009,
           1'b1);
        rd_at({16'hcc11, vme_dec_pkg::OFS_SLOT_ID}, a32, 1'b1);
        chk(mst.rd, 16'h0009);
        do_reset(5'h07, 1'b1);
        geo_r(vme_dec_pkg::OFS_SLOT_ID, 16'h0007);
        geo_r(mc, 16'h00aa);
    endtask
    // ==========================================================
    // Verdict, main sequence and watchdog
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (4) @(negedge SYS_CLK);
        RESET_N = 1'b1;
        repeat (2) @(negedge SYS_CLK);
        t_reset_vals();
        t_geo_refuse();
        t_base_codes();
        t_prog_base();
        t_chain();
        t_no_aux();
        tally_and_finish();
    end
    // Roughly fifty bus cycles of four to six clocks each; far above that is a hang
    initial begin
        #200000;
        fails++;
        tally_and_finish();
    end
endmodule
